// [core/uart_tx_dma_pkg.sv]
// Constants shared by the transmit DMA channel control.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package uart_tx_dma_pkg;
	// Bus geometry
	localparam int ADR_W  = 8;
	localparam int DAT_W  = 32;
	localparam int NUM_CH = 2;
	// Register byte offsets
	localparam logic [7:0] OFS_DEF0  = 8'h00;
	localparam logic [7:0] OFS_DEF1  = 8'h04;
	localparam logic [7:0] OFS_FLAG0 = 8'h08;
	localparam logic [7:0] OFS_FLAG1 = 8'h0c;
	localparam logic [7:0] OFS_ISTAT = 8'h10;
	localparam logic [7:0] OFS_IMASK = 8'h14;
	// Channel definition fields
	localparam int DEF_PTR_W = 3;
	localparam int DEF_PROT  = 3;
	localparam int DEF_BSEL  = 4;
	localparam int DEF_CONT  = 5;
	localparam int DEF_INE   = 6;
	localparam int DEF_EN    = 7;
	localparam logic [7:0] DEF_RESET = 8'h08;
	// Channel flag fields
	localparam int FLG_PART = 0;
	localparam int FLG_TOUT = 1;
	localparam logic [1:0] FLG_RESET = 2'h0;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	// Byte counts
	localparam int CNT_W = 7;
	localparam logic [6:0] PKT_SIZE = 7'h40;
	// Channel sequencer
	typedef enum logic [2:0] {
		ST_IDLE, ST_WAITBUF, ST_READ, ST_WAITDAT, ST_SEND, ST_FINISH
	} chan_state_e;
endpackage

// [core/uart_tx_dma_ctrl.sv]
// Control of the two transmit DMA channels: buffer to transmitter.
// Assumes buffer manager and transmitters are synchronous to clk.
`timescale 1ns/100ps

module uart_tx_dma_ctrl #(
	parameter logic [6:0] BURST_PKT = uart_tx_dma_pkg::PKT_SIZE
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Wishbone slave
	input  wire logic                              wbCyc,
	input  wire logic                              wbStb,
	input  wire logic                              wbWe,
	input  wire logic [uart_tx_dma_pkg::ADR_W-1:0] wbAdr,
	input  wire logic [3:0]                        wbSel,
	input  wire logic [uart_tx_dma_pkg::DAT_W-1:0] wbDatW,
	output logic      [uart_tx_dma_pkg::DAT_W-1:0] wbDatR,
	output logic                                   wbAck,
	// Interrupt
	output logic irq,
	// Buffer manager, one lane per channel
	output logic [1:0][2:0] descPtr,
	output logic [1:0]      bufSelect,
	input  wire logic [1:0]      bufReady,
	input  wire logic [1:0][6:0] bufCount,
	input  wire logic [1:0][6:0] bufSize,
	output logic [1:0]      bufRdReq,
	output logic [1:0][6:0] bufRdIdx,
	input  wire logic [1:0]      rdValid,
	input  wire logic [1:0][7:0] rdData,
	output logic [1:0]      cntWrite,
	output logic [1:0][6:0] cntValue,
	output logic [1:0]      nakClear,
	input  wire logic [1:0]      txTimeout,
	// Serial transmitters
	input  wire logic [1:0]      txReady,
	output logic [1:0]      txWrite,
	output logic [1:0][7:0] txData
);
	import uart_tx_dma_pkg::*;

	// Bus phase and per-channel views
	logic       ackFf;
	logic       wrTake;
	logic [7:0] defView [NUM_CH];
	logic [1:0] flgView [NUM_CH];
	logic [1:0] irqEvt;

	// Address match on a register byte offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a[7:2] == o[7:2]);
	endfunction

	// Writes land on the edge where the master sees ack
	assign wrTake = wbCyc & wbStb & wbWe & ackFf & wbSel[0];

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gCh
			localparam logic [7:0] OFS_D = (g == 0) ? OFS_DEF0 : OFS_DEF1;
			localparam logic [7:0] OFS_F = (g == 0) ? OFS_FLAG0 : OFS_FLAG1;
			chan_state_e stateFf, nxt_state;
			logic [7:0] defFf, nxt_def;        // Channel definition
			logic [1:0] flgFf, nxt_flg;        // Partial and timeout flags
			logic [6:0] idxFf, nxt_idx;        // Byte index in buffer
			logic [6:0] remFf, nxt_rem;        // Bytes still to send
			logic       partFf, nxt_part;      // Current buffer is short
			logic [7:0] txdFf, nxt_txd;
			logic       rdReqFf, nxt_rdReq;
			logic       txWrFf, nxt_txWr;
			logic       cntWrFf, nxt_cntWr;
			logic [6:0] cntValFf, nxt_cntVal;
			logic       nakFf, nxt_nak;
			logic       halt;                  // Hardware end of transfer
			logic [1:0] flgSet;
			logic [6:0] limit;

			// Sequencer, definition register and flags
			always_comb begin
				nxt_state  = stateFf;
				nxt_def    = defFf;
				nxt_idx    = idxFf;
				nxt_rem    = remFf;
				nxt_part   = partFf;
				nxt_txd    = txdFf;
				nxt_rdReq  = 1'b0;
				nxt_txWr   = 1'b0;
				nxt_cntWr  = 1'b0;
				nxt_cntVal = cntValFf;
				nxt_nak    = 1'b0;
				halt       = 1'b0;
				flgSet     = 2'h0;
				// Short packet threshold depends on the mode
				limit = defFf[DEF_CONT] ? bufSize[g] : BURST_PKT;
				if (stateFf != ST_IDLE && !defFf[DEF_EN]) begin
					// Software dropped enable: abandon quietly
					nxt_state = ST_IDLE;
				end else if (stateFf != ST_IDLE && stateFf != ST_FINISH
						&& txTimeout[g]) begin
					// Transaction timer expired
					flgSet[FLG_TOUT] = 1'b1;
					nxt_cntWr  = 1'b1;
					nxt_cntVal = remFf;
					nxt_nak    = 1'b1;
					halt       = defFf[DEF_INE];
					nxt_state  = halt ? ST_IDLE : ST_WAITBUF;
				end else begin
					case (stateFf)
						ST_IDLE: begin
							// Software start
							if (defFf[DEF_EN]) begin
								nxt_state = ST_WAITBUF;
							end
						end
						ST_WAITBUF: begin
							// Buffer chosen by pointer and select is filled
							if (bufReady[g]) begin
								nxt_rem   = bufCount[g];
								nxt_idx   = 7'h00;
								nxt_part  = (bufCount[g] < limit);
								nxt_state = (bufCount[g] == 7'h00) ? ST_FINISH : ST_READ;
							end
						end
						ST_READ: begin
							// Fetch one byte from the buffer
							nxt_rdReq = 1'b1;
							nxt_state = ST_WAITDAT;
						end
						ST_WAITDAT: begin
							if (rdValid[g]) begin
								nxt_txd   = rdData[g];
								nxt_state = ST_SEND;
							end
						end
						ST_SEND: begin
							// Hand the byte to this channel's transmitter
							if (txReady[g]) begin
								nxt_txWr  = 1'b1;
								nxt_idx   = idxFf + 7'h01;
								nxt_rem   = remFf - 7'h01;
								nxt_state = (remFf == 7'h01) ? ST_FINISH : ST_READ;
							end
						end
						ST_FINISH: begin
							// Count reached zero: write back and release buffer
							nxt_cntWr  = 1'b1;
							nxt_cntVal = remFf;
							nxt_nak    = 1'b1;
							if (partFf) begin
								flgSet[FLG_PART] = 1'b1;
							end
							if (defFf[DEF_CONT]) begin
								// Ping-pong to the other buffer
								nxt_def[DEF_BSEL] = ~defFf[DEF_BSEL];
								halt = partFf & defFf[DEF_INE];
							end else begin
								// Burst ends here unless a short packet is masked
								halt = ~(partFf & ~defFf[DEF_INE]);
							end
							nxt_state = halt ? ST_IDLE : ST_WAITBUF;
						end
						default: nxt_state = ST_IDLE;
					endcase
				end
				if (halt) begin
					nxt_def[DEF_EN] = 1'b0;
				end
				// Software write wins over the hardware update
				if (wrTake && hit(wbAdr, OFS_D)) begin
					nxt_def[DEF_PTR_W-1:0] = wbDatW[DEF_PTR_W-1:0];
					if (!wbDatW[DEF_PROT]) begin
						nxt_def[DEF_BSEL] = wbDatW[DEF_BSEL];
					end
					nxt_def[DEF_CONT] = wbDatW[DEF_CONT];
					nxt_def[DEF_INE]  = wbDatW[DEF_INE];
					nxt_def[DEF_EN]   = wbDatW[DEF_EN];
				end
				nxt_def[DEF_PROT] = 1'b1;
				// Write one clears a flag, a new event still sets it
				nxt_flg = flgFf;
				if (wrTake && hit(wbAdr, OFS_F)) begin
					nxt_flg = flgFf & ~wbDatW[1:0];
				end
				nxt_flg = nxt_flg | flgSet;
			end

			// Register the channel state
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					stateFf  <= ST_IDLE;
					defFf    <= DEF_RESET;
					flgFf    <= FLG_RESET;
					idxFf    <= 7'h00;
					remFf    <= 7'h00;
					partFf   <= 1'b0;
					txdFf    <= 8'h00;
					rdReqFf  <= 1'b0;
					txWrFf   <= 1'b0;
					cntWrFf  <= 1'b0;
					cntValFf <= 7'h00;
					nakFf    <= 1'b0;
				end else begin
					stateFf  <= nxt_state;
					defFf    <= nxt_def;
					flgFf    <= nxt_flg;
					idxFf    <= nxt_idx;
					remFf    <= nxt_rem;
					partFf   <= nxt_part;
					txdFf    <= nxt_txd;
					rdReqFf  <= nxt_rdReq;
					txWrFf   <= nxt_txWr;
					cntWrFf  <= nxt_cntWr;
					cntValFf <= nxt_cntVal;
					nakFf    <= nxt_nak;
				end
			end

			// Interrupt source: enable falls while interrupts enabled
			assign irqEvt[g] = defFf[DEF_EN] & ~nxt_def[DEF_EN] & defFf[DEF_INE];

			// Ports straight from the channel flip-flops
			assign defView[g]   = defFf;
			assign flgView[g]   = flgFf;
			assign descPtr[g]   = defFf[DEF_PTR_W-1:0];
			assign bufSelect[g] = defFf[DEF_BSEL];
			assign bufRdReq[g]  = rdReqFf;
			assign bufRdIdx[g]  = idxFf;
			assign txWrite[g]   = txWrFf;
			assign txData[g]    = txdFf;
			assign cntWrite[g]  = cntWrFf;
			assign cntValue[g]  = cntValFf;
			assign nakClear[g]  = nakFf;
		end
	endgenerate

	// Bus answer and interrupt state
	logic [DAT_W-1:0] rdatFf, nxt_rdat;
	logic             nxt_ack;
	logic [1:0]       istatFf, nxt_istat;  // Sticky per channel
	logic [1:0]       imaskFf, nxt_imask;
	logic             irqFf, nxt_irq;

	// Ack one cycle after the request; unmapped reads return zero
	always_comb begin
		nxt_ack   = wbCyc & wbStb & ~ackFf;
		nxt_rdat  = rdatFf;
		nxt_istat = istatFf;
		nxt_imask = imaskFf;
		if (nxt_ack) begin
			if (hit(wbAdr, OFS_DEF0)) begin
				nxt_rdat = {24'h000000, defView[0]};
			end else if (hit(wbAdr, OFS_DEF1)) begin
				nxt_rdat = {24'h000000, defView[1]};
			end else if (hit(wbAdr, OFS_FLAG0)) begin
				nxt_rdat = {30'h00000000, flgView[0]};
			end else if (hit(wbAdr, OFS_FLAG1)) begin
				nxt_rdat = {30'h00000000, flgView[1]};
			end else if (hit(wbAdr, OFS_ISTAT)) begin
				nxt_rdat = {30'h00000000, istatFf};
			end else if (hit(wbAdr, OFS_IMASK)) begin
				nxt_rdat = {30'h00000000, imaskFf};
			end else begin
				nxt_rdat = 32'h00000000;
			end
		end
		// Status: write one clears, same-cycle event still sets
		if (wrTake && hit(wbAdr, OFS_ISTAT)) begin
			nxt_istat = istatFf & ~wbDatW[1:0];
		end
		nxt_istat = nxt_istat | irqEvt;
		if (wrTake && hit(wbAdr, OFS_IMASK)) begin
			nxt_imask = wbDatW[1:0];
		end
		// Level output, registered so it is glitch free
		nxt_irq = |(nxt_istat & nxt_imask);
	end

	// Register bus and interrupt state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ackFf   <= 1'b0;
			rdatFf  <= 32'h00000000;
			istatFf <= IRQ_RESET;
			imaskFf <= IRQ_RESET;
			irqFf   <= 1'b0;
		end else begin
			ackFf   <= nxt_ack;
			rdatFf  <= nxt_rdat;
			istatFf <= nxt_istat;
			imaskFf <= nxt_imask;
			irqFf   <= nxt_irq;
		end
	end

	assign wbAck  = ackFf;
	assign wbDatR = rdatFf;
	assign irq    = irqFf;
endmodule

// [tb/uart_tx_dma_ctrl_sva.sv]
// Checker for the transmit DMA channel control, lane 0.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module uart_tx_dma_ctrl_sva (
	// Clock and reset
	input wire logic                              clk,
	input wire logic                              resetn,
	// Register bus
	input wire logic                              wbCyc,
	input wire logic                              wbStb,
	input wire logic                              wbWe,
	input wire logic [uart_tx_dma_pkg::ADR_W-1:0] wbAdr,
	input wire logic [3:0]                        wbSel,
	input wire logic [uart_tx_dma_pkg::DAT_W-1:0] wbDatW,
	input wire logic [uart_tx_dma_pkg::DAT_W-1:0] wbDatR,
	input wire logic                              wbAck,
	// Channel side
	input wire logic [1:0][2:0]                   descPtr,
	input wire logic [1:0]                        bufSelect,
	input wire logic [1:0]                        cntWrite,
	input wire logic [1:0]                        nakClear,
	input wire logic [1:0]                        txReady,
	input wire logic [1:0]                        txWrite
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Accepted write to the lane 0 definition register
	wire wrDef = wbCyc && wbStb && wbAck && wbWe && wbSel[0] && wbAdr == 8'h00;
	a_ack_next: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
		else $error("ack late");
	a_ack_pulse: assert property (wbAck |=> !wbAck)
		else $error("ack too long");
	a_prot_read: assert property (wbAck && !wbWe && wbAdr[7:3] == 5'h00 |-> wbDatR[3])
		else $error("protect bit reads zero");
	a_ptr_load: assert property (wrDef |=> descPtr[0] == $past(wbDatW[2:0]))
		else $error("pointer not loaded");
	a_bsel_keep: assert property (wrDef && wbDatW[3] && !wbDatW[5] |=> $stable(bufSelect[0]))
		else $error("select changed under protect");
	a_bsel_load: assert property (wrDef && !wbDatW[3] |=> bufSelect[0] == $past(wbDatW[4]))
		else $error("select not loaded");
	a_nak_pair: assert property (nakClear[0] == cntWrite[0])
		else $error("nak clear apart from count write");
	a_tx_pulse: assert property (txWrite[0] |=> !txWrite[0])
		else $error("transmit write too long");
	a_tx_ready: assert property (txWrite[0] |-> $past(txReady[0]))
		else $error("write without ready");
endmodule

// [tb/tx_side_model.sv]
// Buffer manager read port and transmitter ready, both lanes.
// Assumes one read per request; data encodes select and index.
`timescale 1ns/100ps
module tx_side_model (
	input  wire logic            clk,
	input  wire logic            resetn,
	input  wire logic [1:0]      bufRdReq,
	input  wire logic [1:0][6:0] bufRdIdx,
	input  wire logic [1:0]      bufSelect,
	output logic [1:0]           rdValid,
	output logic [1:0][7:0]      rdData,
	output logic [1:0]           txReady
);
	logic [1:0] req_ff;   // Read latency of two cycles
	logic [2:0] stall_ff; // Transmitter busy one cycle in eight
	// Off-cycle data is inverted each cycle, so a stale byte repeats the last read only every other cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			req_ff <= 2'h0;
			rdValid <= 2'h0;
			rdData <= '0;
			stall_ff <= 3'h0;
		end else begin
			req_ff <= bufRdReq;
			rdValid <= req_ff;
			stall_ff <= stall_ff + 3'h1;
			for (int g = 0; g < 2; g++) begin
				rdData[g] <= req_ff[g] ? {bufSelect[g], bufRdIdx[g]} ^ 8'h5a : ~rdData[g];
			end
		end
	end
	assign txReady = {2{stall_ff != 3'h0}};
endmodule

// [tb/uart_tx_dma_ctrl_bench.sv]
// Self-checking bench: registers, burst, continuous and timeout on lane 0.
// Assumes the model above answers reads and paces the transmitter.
`timescale 1ns/100ps
module uart_tx_dma_ctrl_bench;
	import uart_tx_dma_pkg::*;
	logic clk, resetn, wbCyc, wbStb, wbWe, wbAck, irq;
	logic [7:0] wbAdr, rd;
	logic [3:0] wbSel;
	logic [31:0] wbDatW, wbDatR, seed;
	logic [1:0][2:0] descPtr;
	logic [1:0] bufSelect, bufReady, bufRdReq, rdValid, cntWrite, nakClear;
	logic [1:0] txTimeout, txReady, txWrite;
	logic [1:0][6:0] bufCount, bufSize, bufRdIdx, cntValue;
	logic [1:0][7:0] rdData, txData;
	int miscompares, num_checks;
	uart_tx_dma_ctrl uut (.clk(clk), .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb),
		.wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
		.wbAck(wbAck), .irq(irq), .descPtr(descPtr), .bufSelect(bufSelect),
		.bufReady(bufReady), .bufCount(bufCount), .bufSize(bufSize), .bufRdReq(bufRdReq),
		.bufRdIdx(bufRdIdx), .rdValid(rdValid), .rdData(rdData), .cntWrite(cntWrite),
		.cntValue(cntValue), .nakClear(nakClear), .txTimeout(txTimeout),
		.txReady(txReady), .txWrite(txWrite), .txData(txData));
	tx_side_model partner (.clk(clk), .resetn(resetn), .bufRdReq(bufRdReq),
		.bufRdIdx(bufRdIdx), .bufSelect(bufSelect), .rdValid(rdValid), .rdData(rdData),
		.txReady(txReady));
	always #25 clk = ~clk;
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	// Classic single cycle; read data taken at the ack edge
	task automatic wb(logic [7:0] a, logic w, logic [7:0] d);
		int n;
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatW <= {24'h0, d};
		for (n = 0; n < 50 && wbAck !== 1'b1; n++) @(posedge clk);
		rd = wbDatR[7:0];
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		if (n == 50) begin
			miscompares++;
			conclude();
		end
	endtask
	// One buffer on lane 0; optional timeout after the first read
	task automatic xfer(logic [6:0] n, logic [6:0] sz, logic tmo);
		int k, t;
		logic s;
		bufCount[0] <= n;
		bufSize[0] <= sz;
		bufReady[0] <= 1'b1;
		k = 0;
		for (t = 0; t < 2000; t++) begin
			@(posedge clk);
			// Select is taken one edge later, once the enabling write has landed
			if (t == 0) s = bufSelect[0];
			// One-cycle timer pulse on the first read when asked for
			txTimeout[0] <= (bufRdReq[0] === 1'b1 && tmo && k == 0);
			if (bufRdReq[0] === 1'b1) bufReady[0] <= 1'b0;
			if (txWrite[0] === 1'b1) begin
				chk("txData", {s, k[6:0]} ^ 8'h5a, txData[0]);
				k++;
			end
			if (cntWrite[0] === 1'b1) break;
		end
		if (t == 2000) begin
			miscompares++;
			conclude();
		end
		chk("nakClear", 8'h01, {7'h0, nakClear[0]});
		if (!tmo) chk("bytes", {1'b0, n}, k[7:0]);
		if (!tmo) chk("cntValue", 8'h00, {1'b0, cntValue[0]});
		if (tmo) chk("cntLeft", {1'b0, n - k[6:0]}, {1'b0, cntValue[0]});
	endtask
	initial begin
		clk = 0; resetn = 0; wbCyc = 0; wbStb = 0; wbWe = 0; wbAdr = 0; wbSel = 4'hf;
		wbDatW = 0; bufReady = 0; bufCount = 0; bufSize = 0; txTimeout = 0;
		seed = 32'h85cb; miscompares = 0; num_checks = 0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		wb(8'h04, 0, 0); chk("def1", DEF_RESET, rd);
		wb(8'h20, 0, 0); chk("unmapped", 8'h00, rd);
		seed = lfsr(seed);
		wb(8'h00, 1, {5'h02, seed[2:0]}); wb(8'h00, 0, 0);
		chk("def0", {5'h03, seed[2:0]}, rd);
		chk("descPtr", {5'h0, seed[2:0]}, {5'h0, descPtr[0]});
		wb(8'h00, 1, 8'h0a); wb(8'h00, 0, 0); chk("def0", 8'h1a, rd);
		wb(8'h04, 1, 8'h16); wb(8'h04, 0, 0); chk("def1", 8'h1e, rd);
		chk("descPtr1", 8'h06, {5'h0, descPtr[1]});
		chk("bufSelect1", 8'h01, {7'h0, bufSelect[1]});
		wb(8'h00, 1, 8'hc0); xfer(7'h40, 7'h40, 0);
		wb(8'h00, 0, 0); chk("def0", 8'h48, rd);
		wb(8'h10, 0, 0); chk("istat", 8'h01, rd);
		wb(8'h14, 1, 8'h01); repeat (2) @(posedge clk); chk("irq", 8'h01, {7'h0, irq});
		wb(8'h10, 1, 8'h01); repeat (2) @(posedge clk); chk("irq", 8'h00, {7'h0, irq});
		seed = lfsr(seed);
		// Short burst: count forced into 1..63, below the packet size
		wb(8'h00, 1, 8'h80); xfer((seed[6:0] | 7'h01) & 7'h3f, 7'h40, 0);
		wb(8'h00, 0, 0); chk("def0", 8'h88, rd);
		wb(8'h08, 0, 0); chk("flags", 8'h01, rd);
		wb(8'h10, 0, 0); chk("istat", 8'h00, rd);
		wb(8'h08, 1, 8'h03); wb(8'h00, 1, 8'h08);
		wb(8'h00, 1, 8'he0); xfer(7'h03, 7'h03, 0);
		chk("bufSelect", 8'h01, {7'h0, bufSelect[0]});
		xfer(7'h02, 7'h03, 0); wb(8'h00, 0, 0); chk("enable", 8'h00, {7'h0, rd[7]});
		wb(8'h08, 1, 8'h03); wb(8'h00, 1, 8'he0); xfer(7'h05, 7'h05, 1);
		wb(8'h08, 0, 0); chk("flags", 8'h02, rd);
		wb(8'h00, 0, 0); chk("enable", 8'h00, {7'h0, rd[7]});
		conclude();
	end
endmodule
bind uart_tx_dma_ctrl uart_tx_dma_ctrl_sva chk_i (.clk(clk), .resetn(resetn), .wbCyc(wbCyc),
	.wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
	.wbDatR(wbDatR), .wbAck(wbAck), .descPtr(descPtr), .bufSelect(bufSelect),
	.cntWrite(cntWrite), .nakClear(nakClear), .txReady(txReady), .txWrite(txWrite));
